// >>> hdl/sr_in_sync.sv
// two-stage synchroniser for the trigger and comparator inputs
`timescale 1ns/10ps
module sr_in_sync (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [3:0] raw_in,
	sr_sync_if.src outs
);
	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
	} sync_state_t;
	sync_state_t st_r, st_nxt;
	always_comb begin
		st_nxt.s1 = raw_in;
		st_nxt.s2 = st_r.s1;
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt; // see RULE17
		end
	end
	assign outs.trig = st_r.s2[0];
	assign outs.sense_on = st_r.s2[1];
	assign outs.sense_off = st_r.s2[2];
	assign outs.sense_rearm = st_r.s2[3];
endmodule

// >>> hdl/sr_sync_if.sv
// synchronised input bundle between synchroniser and controller
`timescale 1ns/10ps
interface sr_sync_if;
	logic trig;
	logic sense_on;
	logic sense_off;
	logic sense_rearm;
	modport src (output trig, output sense_on, output sense_off, output sense_rearm);
	modport dst (input trig, input sense_on, input sense_off, input sense_rearm);
endinterface

// >>> hdl/sr_trig_params.svh
// constants and timing counts of the trigger/disable control block
// What this block does
// RULE1 - trigger high forces gate drive off
// RULE2 - ignore trigger during blanking after turn-on
// RULE3 - trigger outranks sense outside blanking
// RULE4 - long trigger high enters disable mode
// RULE5 - trigger low long enough exits disable
// RULE6 - turn on only on falling sense, trigger low
// RULE7 - trigger high at blank expiry turns off
// RULE8 - trigger pulse ended in blanking is filtered
// RULE9 - late narrow trigger gives blank-length pulse
// RULE10 - trigger overrides minimum conduction time
// RULE11 - sense turn-off only after minimum conduction
// RULE12 - drive held low through wake recovery
// RULE13 - drive held low entering disable mode
// RULE14 - minimum off time completes before next pulse
// RULE15 - off timer restarts above rearm, clears below
// RULE16 - separate configurable timers on internal clock
// RULE17 - inputs synchronised before state machine use
`ifndef SR_TRIG_PARAMS_SVH
`define SR_TRIG_PARAMS_SVH
`define CLK_PERIOD_NS 40
`define TRIG_BLANK_NS 120
`define MIN_COND_NS 400
`define MIN_OFF_NS 400
`define DIS_ENTRY_NS 2000
`define DIS_EXIT_NS 1000
`define WAKE_REC_NS 4000
`define CNT_W 8
`define CYC_UP(t) ((((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
	(((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define BLANK_CYC `CYC_UP(`TRIG_BLANK_NS)
`define MIN_COND_CYC `CYC_UP(`MIN_COND_NS)
`define MIN_OFF_CYC `CYC_UP(`MIN_OFF_NS)
`define DIS_ENTRY_CYC `CYC_UP(`DIS_ENTRY_NS)
`define DIS_EXIT_CYC `CYC_UP(`DIS_EXIT_NS)
`define WAKE_REC_CYC `CYC_UP(`WAKE_REC_NS)
`endif

// >>> hdl/sr_trig_pkg.sv
// types of the trigger/disable control block
package sr_trig_pkg;
	typedef enum logic [4:0] {
		ST_ARM = 5'h01,
		ST_ON = 5'h02,
		ST_OFF = 5'h04,
		ST_DIS = 5'h08,
		ST_REC = 5'h10
	} drv_state_t;
endpackage

// >>> hdl/sr_trigger_disable_logic.sv
// gate drive control around the trigger/disable input
`timescale 1ns/10ps
`include "sr_trig_params.svh"
module sr_trigger_disable_logic
	import sr_trig_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic trigger_disable_input,
	input wire logic sense_below_on,
	input wire logic sense_above_off,
	input wire logic sense_above_rearm,
	output logic gate_drive_output,
	output logic disable_mode
);
	localparam logic [`CNT_W-1:0] BLANK_C = `CNT_W'(`BLANK_CYC); // see RULE16
	localparam logic [`CNT_W-1:0] COND_C = `CNT_W'(`MIN_COND_CYC);
	localparam logic [`CNT_W-1:0] OFF_C = `CNT_W'(`MIN_OFF_CYC);
	localparam logic [`CNT_W-1:0] ENTRY_C = `CNT_W'(`DIS_ENTRY_CYC);
	localparam logic [`CNT_W-1:0] EXIT_C = `CNT_W'(`DIS_EXIT_CYC);
	localparam logic [`CNT_W-1:0] REC_C = `CNT_W'(`WAKE_REC_CYC);

	sr_sync_if sy ();

	sr_in_sync sr_in_sync_i (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.raw_in({sense_above_rearm, sense_above_off, sense_below_on, trigger_disable_input}),
		.outs(sy.src)
	);

	typedef struct packed {
		drv_state_t st;
		logic drv;
		logic dis;
		logic on_prev;
		logic off_done;
		logic [`CNT_W-1:0] blank_cnt;
		logic [`CNT_W-1:0] cond_cnt;
		logic [`CNT_W-1:0] off_cnt;
		logic [`CNT_W-1:0] hi_cnt;
		logic [`CNT_W-1:0] lo_cnt;
		logic [`CNT_W-1:0] rec_cnt;
	} ctl_state_t;

	ctl_state_t s_r, s_nxt;

	function automatic logic [`CNT_W-1:0] dec_sat(input logic [`CNT_W-1:0] v);
		dec_sat = (v == '0) ? '0 : v - `CNT_W'(1);
	endfunction

	function automatic logic [`CNT_W-1:0] inc_sat(input logic [`CNT_W-1:0] v);
		inc_sat = (v == '1) ? v : v + `CNT_W'(1);
	endfunction

	logic on_edge;
	logic blanking;
	assign on_edge = sy.sense_on && !s_r.on_prev;
	assign blanking = s_r.blank_cnt != '0;

	always_comb begin
		s_nxt = s_r;
		s_nxt.on_prev = sy.sense_on;
		s_nxt.blank_cnt = dec_sat(s_r.blank_cnt);
		s_nxt.cond_cnt = dec_sat(s_r.cond_cnt);
		// trigger high/low duration counters for disable entry and exit
		s_nxt.hi_cnt = sy.trig ? inc_sat(s_r.hi_cnt) : '0; // see RULE4
		s_nxt.lo_cnt = sy.trig ? '0 : inc_sat(s_r.lo_cnt); // see RULE5
		// minimum off timer runs only while sense is above rearm level
		if (!sy.sense_rearm) begin
			s_nxt.off_cnt = '0; // see RULE15
		end else if (s_r.off_cnt != OFF_C) begin
			s_nxt.off_cnt = s_r.off_cnt + `CNT_W'(1); // see RULE15
		end
		if (s_r.st == ST_ON) begin
			s_nxt.off_done = 1'b0;
		end else if (s_nxt.off_cnt == OFF_C) begin
			s_nxt.off_done = 1'b1;
		end
		unique case (s_r.st)
			ST_ARM: begin
				if (s_r.hi_cnt >= ENTRY_C) begin
					s_nxt.st = ST_DIS; // see RULE4
					s_nxt.dis = 1'b1;
					s_nxt.drv = 1'b0; // see RULE13
				end else if (on_edge && !sy.trig && s_r.off_done) begin
					s_nxt.st = ST_ON; // see RULE6
					s_nxt.drv = 1'b1;
					// counters hold the cycles left after the turn-on cycle itself
					s_nxt.blank_cnt = BLANK_C - `CNT_W'(1); // see RULE2 RULE9
					s_nxt.cond_cnt = COND_C - `CNT_W'(1); // see RULE11
				end
			end
			ST_ON: begin
				if (!blanking && sy.trig) begin
					// covers expiry with trigger high and plain override
					s_nxt.st = ST_OFF; // see RULE1 RULE3 RULE7 RULE8 RULE9 RULE10
					s_nxt.drv = 1'b0;
					s_nxt.off_done = 1'b0;
				end else if (!blanking && s_r.cond_cnt == '0 && sy.sense_off) begin
					s_nxt.st = ST_OFF; // see RULE11
					s_nxt.drv = 1'b0;
					s_nxt.off_done = 1'b0;
				end
			end
			ST_OFF: begin
				s_nxt.st = ST_ARM; // see RULE14
				s_nxt.off_cnt = '0;
				s_nxt.off_done = 1'b0;
			end
			ST_DIS: begin
				s_nxt.drv = 1'b0;
				if (s_r.lo_cnt >= EXIT_C) begin
					s_nxt.st = ST_REC; // see RULE5
					s_nxt.rec_cnt = REC_C;
				end
			end
			ST_REC: begin
				s_nxt.drv = 1'b0; // see RULE12
				s_nxt.rec_cnt = dec_sat(s_r.rec_cnt);
				s_nxt.off_cnt = '0;
				s_nxt.off_done = 1'b0;
				if (s_r.rec_cnt == `CNT_W'(1)) begin
					s_nxt.st = ST_ARM;
					s_nxt.dis = 1'b0;
				end
			end
			default: begin
				s_nxt.st = ST_ARM;
				s_nxt.drv = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_r <= '{st: ST_ARM, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign gate_drive_output = s_r.drv;
	assign disable_mode = s_r.dis;

	property p_blank_hold;
		@(posedge sys_clk) disable iff (!nrst)
		$rose(s_r.drv) |-> s_r.drv [*3];
	endproperty
	a_blank_hold: assert property (p_blank_hold) else $error("drive dropped in blanking"); // see RULE2

	property p_blank_len;
		@(posedge sys_clk) disable iff (!nrst)
		($rose(s_r.drv) ##2 sy.trig) |=> !s_r.drv;
	endproperty
	a_blank_len: assert property (p_blank_len) else $error("blank too long"); // see RULE9

	property p_trig_off;
		@(posedge sys_clk) disable iff (!nrst)
		(s_r.st == ST_ON && !blanking && sy.trig) |=> !s_r.drv;
	endproperty
	a_trig_off: assert property (p_trig_off) else $error("trigger did not stop drive"); // see RULE3

	property p_on_cond;
		@(posedge sys_clk) disable iff (!nrst)
		$rose(s_r.drv) |-> $past(on_edge) && !$past(sy.trig);
	endproperty
	a_on_cond: assert property (p_on_cond) else $error("illegal drive turn-on"); // see RULE6

	property p_min_cond;
		@(posedge sys_clk) disable iff (!nrst)
		($fell(s_r.drv) && !$past(sy.trig)) |-> $past(s_r.cond_cnt) == '0;
	endproperty
	a_min_cond: assert property (p_min_cond) else $error("sense off before min time"); // see RULE11

	property p_dis_low;
		@(posedge sys_clk) disable iff (!nrst)
		s_r.dis |-> !s_r.drv;
	endproperty
	a_dis_low: assert property (p_dis_low) else $error("drive high in disable"); // see RULE13

	property p_rec_low;
		@(posedge sys_clk) disable iff (!nrst)
		(s_r.st == ST_REC) |-> !s_r.drv;
	endproperty
	a_rec_low: assert property (p_rec_low) else $error("drive high in recovery"); // see RULE12

	property p_off_done;
		@(posedge sys_clk) disable iff (!nrst)
		$rose(s_r.drv) |-> $past(s_r.off_done);
	endproperty
	a_off_done: assert property (p_off_done) else $error("on before min off time"); // see RULE14

	property p_rearm_clr;
		@(posedge sys_clk) disable iff (!nrst)
		!sy.sense_rearm |=> s_r.off_cnt == '0;
	endproperty
	a_rearm_clr: assert property (p_rearm_clr) else $error("off timer not cleared"); // see RULE15

	property p_entry;
		@(posedge sys_clk) disable iff (!nrst)
		(s_r.st == ST_ARM && s_r.hi_cnt >= ENTRY_C) |=> s_r.dis;
	endproperty
	a_entry: assert property (p_entry) else $error("disable not entered"); // see RULE4
endmodule

// >>> verif/sr_far_side.sv
// far-side model: primary trigger source and sense comparators
`timescale 1ns/10ps
module sr_far_side (
	input wire logic sys_clk,
	output logic trigger_disable_input,
	output logic sense_below_on,
	output logic sense_above_off,
	output logic sense_above_rearm
);
	initial begin
		trigger_disable_input = 1'h0;
		sense_below_on = 1'h0;
		sense_above_off = 1'h1;
		sense_above_rearm = 1'h1;
	end
	// level 0 conducting, 1 drain high, 2 past turn-off but under rearm
	task automatic sense(input int lvl);
		@(posedge sys_clk);
		sense_below_on <= (lvl == 0);
		sense_above_off <= (lvl != 0);
		sense_above_rearm <= (lvl == 1);
	endtask
	task automatic trig(input logic v, input int n);
		@(posedge sys_clk);
		trigger_disable_input <= v;
		repeat (n) @(posedge sys_clk);
	endtask
endmodule

// >>> verif/tb_top.sv
// self-checking bench of the trigger/disable control block
`timescale 1ns/10ps
module tb_top;
	logic sys_clk;
	logic nrst;
	logic trg, bon, boff, brr, gate, dis;
	int n_mismatch = 0;
	int checked = 0;
	sr_far_side sr_far_side_i (.sys_clk(sys_clk), .trigger_disable_input(trg),
		.sense_below_on(bon), .sense_above_off(boff), .sense_above_rearm(brr));
	sr_trigger_disable_logic sr_trigger_disable_logic_i (.sys_clk(sys_clk), .nrst(nrst),
		.trigger_disable_input(trg), .sense_below_on(bon), .sense_above_off(boff),
		.sense_above_rearm(brr), .gate_drive_output(gate), .disable_mode(dis));
	initial begin
		sys_clk = 1'h0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic seen, input logic exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: saw %b expected %b", $time, seen, exp);
		end
	endtask
	// wait up to n cycles for the gate to reach v
	task automatic wt(input logic v, input int n);
		for (int i = 0; i < n && gate !== v; i++) @(negedge sys_clk);
		chk(gate, v);
	endtask
	// full off time with drain high, then a falling sense edge
	task automatic arm();
		sr_far_side_i.sense(1);
		repeat (14) @(posedge sys_clk);
		sr_far_side_i.sense(0);
		@(negedge sys_clk);
	endtask
	task automatic t_trig_off();
		arm();
		wt(1'h1, 6);
		repeat (5) @(negedge sys_clk);
		sr_far_side_i.trig(1'h1, 0);
		wt(1'h0, 4);
		sr_far_side_i.trig(1'h0, 0);
		$display("trigger turn-off done");
	endtask
	task automatic t_blank();
		// trigger seen inside blanking and still high at expiry: blank-long pulse
		arm();
		sr_far_side_i.trig(1'h1, 0);
		wt(1'h1, 6);
		repeat (2) @(negedge sys_clk);
		chk(gate, 1'h1);
		@(negedge sys_clk);
		chk(gate, 1'h0);
		sr_far_side_i.trig(1'h0, 0);
		// two-cycle pulse that is over before blanking ends
		arm();
		sr_far_side_i.trig(1'h1, 1);
		sr_far_side_i.trig(1'h0, 0);
		wt(1'h1, 6);
		repeat (7) @(negedge sys_clk);
		chk(gate, 1'h1);
		$display("blanking done");
	endtask
	task automatic t_cond_off();
		// early turn-off crossing: drive lasts exactly the minimum conduction time
		arm();
		sr_far_side_i.sense(2);
		repeat (5) @(negedge sys_clk);
		chk(gate, 1'h1);
		repeat (7) @(negedge sys_clk);
		chk(gate, 1'h1);
		@(negedge sys_clk);
		chk(gate, 1'h0);
		sr_far_side_i.sense(0);
		repeat (8) @(negedge sys_clk);
		chk(gate, 1'h0);
		sr_far_side_i.sense(1);
		repeat (6) @(posedge sys_clk);
		sr_far_side_i.sense(2);
		sr_far_side_i.sense(1);
		repeat (7) @(posedge sys_clk);
		sr_far_side_i.sense(0);
		repeat (8) @(negedge sys_clk);
		chk(gate, 1'h0);
		$display("conduction and off time done");
	endtask
	task automatic t_refuse();
		sr_far_side_i.trig(1'h1, 0);
		arm();
		repeat (6) @(negedge sys_clk);
		chk(gate, 1'h0);
		sr_far_side_i.trig(1'h0, 0);
		repeat (6) @(negedge sys_clk);
		chk(gate, 1'h0);
		$display("refusal done");
	endtask
	task automatic t_disable();
		sr_far_side_i.sense(1);
		sr_far_side_i.trig(1'h1, 60);
		@(negedge sys_clk);
		chk(dis, 1'h1);
		chk(gate, 1'h0);
		sr_far_side_i.trig(1'h0, 29);
		for (int i = 0; i < 140 && dis === 1'h1; i++) begin
			if (gate !== 1'h0) chk(gate, 1'h0);
			@(negedge sys_clk);
		end
		chk(dis, 1'h0);
		arm();
		wt(1'h1, 6);
		$display("disable mode done");
	endtask
	task automatic stop_test();
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		nrst = 1'h0;
		repeat (12) @(posedge sys_clk);
		nrst <= 1'h1;
		t_trig_off();
		t_blank();
		t_cond_off();
		t_refuse();
		t_disable();
		stop_test();
	end
	initial begin
		#100us;
		n_mismatch++;
		stop_test();
	end
endmodule
